// ===== hai_pkg.sv
package hai_pkg;

	// ------------------------------------------------------------------
	// Widths and field positions
	// ------------------------------------------------------------------
	localparam int HAI_DATA_W = 32;
	localparam int HAI_INSN_W = 16;
	localparam int HAI_OP_W = 12;
	localparam int HAI_REG_W = 5;
	localparam int HAI_CLASS_LSB = 12;
	localparam int HAI_REG_FILE_BIT = 4;
	localparam int HAI_UNIT_MSB = 11;
	localparam int HAI_UNIT_LSB = 10;

	// ------------------------------------------------------------------
	// Encodings and reset values
	// ------------------------------------------------------------------
	localparam logic [3:0] HAI_CLASS_CODE = 4'h4;
	localparam logic HAI_STROBE_OFF = 1'b1;
	localparam logic HAI_STROBE_ON = 1'b0;
	localparam logic [HAI_OP_W-1:0] HAI_OP_RESET = 12'h000;
	localparam logic [HAI_DATA_W-1:0] HAI_DATA_RESET = 32'h0000_0000;
	localparam logic [HAI_REG_W-1:0] HAI_REG_RESET = 5'h00;

	// ------------------------------------------------------------------
	// Instruction handshake states, Gray coded along idle, decode, gap
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		HAI_ST_IDLE = 2'b00,
		HAI_ST_DECODE = 2'b01,
		HAI_ST_GAP = 2'b11
	} hai_state_t;

endpackage : hai_pkg

// ===== hai_hold_if.sv
`timescale 1ns/100ps
interface hai_hold_if;
	logic busy_n_raw;
	logic exc_n_raw;
	logic dec_active;
	logic busy_n_held;
	logic exc_n_held;

	modport core (
		output busy_n_raw,
		output exc_n_raw,
		output dec_active,
		input busy_n_held,
		input exc_n_held
	);

	modport hold (
		input busy_n_raw,
		input exc_n_raw,
		input dec_active,
		output busy_n_held,
		output exc_n_held
	);
endinterface : hai_hold_if

// ===== hai_hold.sv
`timescale 1ns/100ps
module hai_hold
	import hai_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Shared input holding path
	hai_hold_if.hold hh
);

	logic busy_last_q;
	logic exc_last_q;

	// ------------------------------------------------------------------
	// Holding stage
	// ------------------------------------------------------------------
	// The shared lines are only driven while decode is asserted; outside
	// that window the last driven value is replayed so nothing floats.
	assign hh.busy_n_held = hh.dec_active ? hh.busy_n_raw : busy_last_q;
	assign hh.exc_n_held = hh.dec_active ? hh.exc_n_raw : exc_last_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			busy_last_q <= HAI_STROBE_OFF;
			exc_last_q <= HAI_STROBE_OFF;
		end else if (hh.dec_active) begin
			busy_last_q <= hh.busy_n_raw;
			exc_last_q <= hh.exc_n_raw;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_hold_keeps;
		@(posedge ref_clk) disable iff (reset)
		(hh.dec_active ##1 !hh.dec_active) |->
			(hh.busy_n_held == $past(hh.busy_n_raw)) &&
			(hh.exc_n_held == $past(hh.exc_n_raw));
	endproperty
	a_hold_keeps: assert property (p_hold_keeps) else $error("held value lost");

endmodule : hai_hold

// ===== hai_port.sv
`timescale 1ns/100ps
module hai_port
	import hai_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Core register-file write snoop
	input wire logic gpr_wr_en,
	input wire logic gpr_wr_alt,
	input wire logic [HAI_REG_W-2:0] gpr_wr_num,
	input wire logic [HAI_DATA_W-1:0] gpr_wr_data,
	// Core decode stage, describing the decode register after this edge
	input wire logic ir_valid_d,
	input wire logic [HAI_INSN_W-1:0] ir_insn_d,
	input wire logic pipe_ready,
	input wire logic flush,
	input wire logic psr_supervisor,
	// Answers to the core pipeline
	output logic core_issue,
	output logic core_stall,
	output logic core_accel_exc_q,
	// Accelerator pins
	output logic reg_write_strobe_n,
	output logic [HAI_REG_W-1:0] snoop_reg_index,
	output logic [HAI_DATA_W-1:0] accel_data_out,
	output logic accel_data_oe_n,
	input wire logic [HAI_DATA_W-1:0] accel_data_in,
	output logic [HAI_OP_W-1:0] accel_opcode_bus,
	output logic accel_supervisor_flag,
	output logic accel_decode_strobe_n,
	output logic accel_issue_strobe_n,
	input wire logic accel_busy_n_in,
	input wire logic accel_exception_n_in,
	output logic [HAI_UNIT_MSB-HAI_UNIT_LSB:0] accel_unit_sel
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic is_accel_op(input logic valid, input logic [HAI_INSN_W-1:0] insn);
		is_accel_op = valid && (insn[HAI_INSN_W-1:HAI_CLASS_LSB] == HAI_CLASS_CODE);
	endfunction : is_accel_op

	hai_state_t state_q;
	hai_state_t state_d;
	logic [HAI_OP_W-1:0] opcode_q;
	logic wr_strobe_n_q;
	logic [HAI_REG_W-1:0] wr_index_q;
	logic [HAI_DATA_W-1:0] wr_data_q;
	logic wr_oe_n_q;
	logic sup_q;
	logic issue_n_q;
	logic exc_take_q;
	logic dec_on;
	logic busy_now;
	logic exc_now;
	logic issue_go;
	logic next_is_op;
	logic [HAI_DATA_W-1:0] data_in_seen;

	hai_hold_if hh();

	hai_hold u_hold (
		.ref_clk(ref_clk),
		.reset(reset),
		.hh(hh.hold)
	);

	// ------------------------------------------------------------------
	// Register snoop
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_strobe_n_q <= HAI_STROBE_OFF;
			wr_oe_n_q <= HAI_STROBE_OFF;
			wr_index_q <= HAI_REG_RESET;
			wr_data_q <= HAI_DATA_RESET;
		end else begin
			wr_strobe_n_q <= gpr_wr_en ? HAI_STROBE_ON : HAI_STROBE_OFF;
			wr_oe_n_q <= gpr_wr_en ? HAI_STROBE_ON : HAI_STROBE_OFF;
			if (gpr_wr_en) begin
				wr_index_q <= {gpr_wr_alt, gpr_wr_num};
				wr_data_q <= gpr_wr_data;
			end
		end
	end

	assign reg_write_strobe_n = wr_strobe_n_q;
	assign snoop_reg_index = wr_index_q;
	assign accel_data_out = wr_data_q;
	assign accel_data_oe_n = wr_oe_n_q;
	// Inbound operands belong to the transfer primitives, not this port.
	assign data_in_seen = accel_data_in;

	// ------------------------------------------------------------------
	// Supervisor mirror
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sup_q <= 1'b1;
		end else begin
			sup_q <= psr_supervisor;
		end
	end

	assign accel_supervisor_flag = sup_q;

	// ------------------------------------------------------------------
	// Shared busy and exception inputs
	// ------------------------------------------------------------------
	assign dec_on = (state_q == HAI_ST_DECODE);
	assign hh.busy_n_raw = accel_busy_n_in;
	assign hh.exc_n_raw = accel_exception_n_in;
	assign hh.dec_active = dec_on;
	assign busy_now = dec_on && (hh.busy_n_held == HAI_STROBE_ON);
	// Exception is only looked at with decode on and busy off.
	assign exc_now = dec_on && !busy_now && (hh.exc_n_held == HAI_STROBE_ON);

	// ------------------------------------------------------------------
	// Instruction handshake
	// ------------------------------------------------------------------
	assign next_is_op = is_accel_op(ir_valid_d, ir_insn_d);
	// Issue needs a free accelerator and a ready pipeline; a flush wins.
	assign issue_go = dec_on && !busy_now && pipe_ready && !flush;
	assign core_issue = issue_go;
	assign core_stall = dec_on && !issue_go;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			HAI_ST_IDLE: begin
				if (next_is_op && !flush) begin
					state_d = HAI_ST_DECODE;
				end
			end
			HAI_ST_DECODE: begin
				if (flush) begin
					state_d = HAI_ST_GAP;
				end else if (issue_go) begin
					state_d = next_is_op ? HAI_ST_DECODE : HAI_ST_IDLE;
				end
			end
			HAI_ST_GAP: begin
				state_d = HAI_ST_IDLE;
			end
			default: begin
				state_d = HAI_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q <= HAI_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// The opcode only moves when a fresh instruction enters decode.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			opcode_q <= HAI_OP_RESET;
		end else if (state_d == HAI_ST_DECODE && (state_q != HAI_ST_DECODE || issue_go)) begin
			opcode_q <= ir_insn_d[HAI_OP_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			issue_n_q <= HAI_STROBE_OFF;
			exc_take_q <= 1'b0;
		end else begin
			issue_n_q <= issue_go ? HAI_STROBE_ON : HAI_STROBE_OFF;
			exc_take_q <= issue_go && exc_now;
		end
	end

	assign accel_opcode_bus = opcode_q;
	assign accel_unit_sel = opcode_q[HAI_UNIT_MSB:HAI_UNIT_LSB];
	assign accel_decode_strobe_n = dec_on ? HAI_STROBE_ON : HAI_STROBE_OFF;
	assign accel_issue_strobe_n = issue_n_q;
	assign core_accel_exc_q = exc_take_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_decode_ready;
		!accel_decode_strobe_n && !busy_now && pipe_ready && !flush;
	endsequence

	sequence s_issue_pulse;
		!accel_issue_strobe_n;
	endsequence

	property p_snoop;
		@(posedge ref_clk) disable iff (reset)
		gpr_wr_en |=> !reg_write_strobe_n && !accel_data_oe_n &&
			accel_data_out == $past(gpr_wr_data) &&
			snoop_reg_index == {$past(gpr_wr_alt), $past(gpr_wr_num)};
	endproperty
	a_snoop: assert property (p_snoop) else $error("snoop write not mirrored");

	property p_file_bit;
		@(posedge ref_clk) disable iff (reset)
		gpr_wr_en |=> snoop_reg_index[HAI_REG_FILE_BIT] == $past(gpr_wr_alt);
	endproperty
	a_file_bit: assert property (p_file_bit) else $error("file select wrong");

	property p_sup;
		@(posedge ref_clk) disable iff (reset)
		##1 accel_supervisor_flag == $past(psr_supervisor);
	endproperty
	a_sup: assert property (p_sup) else $error("supervisor flag stale");

	property p_decode_on;
		@(posedge ref_clk) disable iff (reset)
		(state_q == HAI_ST_IDLE && next_is_op && !flush) |=>
			!accel_decode_strobe_n && accel_opcode_bus == $past(ir_insn_d[HAI_OP_W-1:0]);
	endproperty
	a_decode_on: assert property (p_decode_on) else $error("decode strobe missing");

	property p_busy_stall;
		@(posedge ref_clk) disable iff (reset)
		(!accel_decode_strobe_n && busy_now) |=> accel_issue_strobe_n;
	endproperty
	a_busy_stall: assert property (p_busy_stall) else $error("issued while busy");

	property p_issue_follows;
		@(posedge ref_clk) disable iff (reset)
		s_decode_ready |=> s_issue_pulse;
	endproperty
	a_issue_follows: assert property (p_issue_follows) else $error("issue not given");

	property p_issue_cause;
		@(posedge ref_clk) disable iff (reset)
		s_issue_pulse |-> $past(issue_go);
	endproperty
	a_issue_cause: assert property (p_issue_cause) else $error("issue without decode");

	property p_discard;
		@(posedge ref_clk) disable iff (reset)
		(!accel_decode_strobe_n && flush) |=> accel_issue_strobe_n && accel_decode_strobe_n
			##1 accel_decode_strobe_n;
	endproperty
	a_discard: assert property (p_discard) else $error("discard not honoured");

	property p_exc;
		@(posedge ref_clk) disable iff (reset)
		(s_decode_ready and (accel_exception_n_in == HAI_STROBE_ON)) |=>
			core_accel_exc_q and s_issue_pulse;
	endproperty
	a_exc: assert property (p_exc) else $error("exception not taken");

	property p_exc_ignored;
		@(posedge ref_clk) disable iff (reset)
		(accel_decode_strobe_n || busy_now) |=> !core_accel_exc_q;
	endproperty
	a_exc_ignored: assert property (p_exc_ignored) else $error("exception not ignored");

	property p_hold_op;
		@(posedge ref_clk) disable iff (reset)
		(!accel_decode_strobe_n && !issue_go && !flush) |=>
			!accel_decode_strobe_n && $stable(accel_opcode_bus);
	endproperty
	a_hold_op: assert property (p_hold_op) else $error("decode dropped while held");

	property p_back_to_back;
		@(posedge ref_clk) disable iff (reset)
		(s_decode_ready and next_is_op) |=>
			!accel_decode_strobe_n && accel_opcode_bus == $past(ir_insn_d[HAI_OP_W-1:0]);
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("next opcode not shown");

	property p_pipe_wait;
		@(posedge ref_clk) disable iff (reset)
		(!accel_decode_strobe_n && !pipe_ready) |=> accel_issue_strobe_n;
	endproperty
	a_pipe_wait: assert property (p_pipe_wait) else $error("issued before pipeline ready");

endmodule : hai_port

// ===== hai_accel_model.sv
`timescale 1ns/100ps
module hai_accel_model
	import hai_pkg::*;
#(
	parameter logic [1:0] UNIT = 2'h0
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Core side of the handshake
	input wire logic accel_decode_strobe_n,
	input wire logic accel_issue_strobe_n,
	input wire logic [HAI_UNIT_MSB-HAI_UNIT_LSB:0] accel_unit_sel,
	// Scenario controls
	input wire logic busy_req,
	input wire logic exc_req,
	// Shared answer lines and execution count
	output logic accel_busy_n_in,
	output logic accel_exception_n_in,
	output int exec_count
);
	logic drv;
	logic last_busy_n;
	logic last_exc_n;
	logic exc_seen;

	// Released lines show the inverse of the last value, so a core without a holding
	// latch samples a wrong level instead of a lucky leftover.
	assign accel_busy_n_in = drv ? ~busy_req : ~last_busy_n;
	assign accel_exception_n_in = drv ? ~exc_req : ~last_exc_n;

	initial begin
		drv = 1'b0;
		last_busy_n = 1'b1;
		last_exc_n = 1'b1;
		exc_seen = 1'b0;
		exec_count = 0;
	end

	always @(negedge ref_clk) begin
		drv = !reset && !accel_decode_strobe_n && (accel_unit_sel == UNIT);
	end

	// Work starts only on the issue strobe, and never for an op that was refused.
	always @(posedge ref_clk) begin
		if (!accel_issue_strobe_n && !exc_seen) begin
			exec_count = exec_count + 1;
		end
		exc_seen = drv && exc_req && !busy_req;
		if (drv) begin
			last_busy_n = ~busy_req;
			last_exc_n = ~exc_req;
		end
		#1;
		drv = 1'b0;
	end
endmodule : hai_accel_model

// ===== accel_instr_handshake_tb.sv
`timescale 1ns/100ps
module accel_instr_handshake_tb
	import hai_pkg::*;
;
	logic ref_clk, reset, gpr_wr_en, gpr_wr_alt, ir_valid_d, pipe_ready, flush, psr_supervisor;
	logic [3:0] gpr_wr_num;
	logic [31:0] gpr_wr_data, accel_data_out;
	logic [15:0] ir_insn_d;
	logic core_issue, core_stall, core_accel_exc_q, reg_write_strobe_n, accel_data_oe_n;
	logic [4:0] snoop_reg_index;
	logic [11:0] accel_opcode_bus;
	logic accel_supervisor_flag, accel_decode_strobe_n, accel_issue_strobe_n;
	logic accel_busy_n_in, accel_exception_n_in, busy_req, exc_req;
	logic [1:0] accel_unit_sel;
	int exec_count, mismatches, compares, cnt;

	hai_port uut (.ref_clk(ref_clk), .reset(reset), .gpr_wr_en(gpr_wr_en),
		.gpr_wr_alt(gpr_wr_alt), .gpr_wr_num(gpr_wr_num), .gpr_wr_data(gpr_wr_data),
		.ir_valid_d(ir_valid_d), .ir_insn_d(ir_insn_d), .pipe_ready(pipe_ready),
		.flush(flush), .psr_supervisor(psr_supervisor), .core_issue(core_issue),
		.core_stall(core_stall), .core_accel_exc_q(core_accel_exc_q),
		.reg_write_strobe_n(reg_write_strobe_n), .snoop_reg_index(snoop_reg_index),
		.accel_data_out(accel_data_out), .accel_data_oe_n(accel_data_oe_n),
		.accel_data_in(32'h0000_0000), .accel_opcode_bus(accel_opcode_bus),
		.accel_supervisor_flag(accel_supervisor_flag),
		.accel_decode_strobe_n(accel_decode_strobe_n),
		.accel_issue_strobe_n(accel_issue_strobe_n), .accel_busy_n_in(accel_busy_n_in),
		.accel_exception_n_in(accel_exception_n_in), .accel_unit_sel(accel_unit_sel));

	hai_accel_model #(.UNIT(2'h0)) model (.ref_clk(ref_clk), .reset(reset),
		.accel_decode_strobe_n(accel_decode_strobe_n),
		.accel_issue_strobe_n(accel_issue_strobe_n), .accel_unit_sel(accel_unit_sel),
		.busy_req(busy_req), .exc_req(exc_req), .accel_busy_n_in(accel_busy_n_in),
		.accel_exception_n_in(accel_exception_n_in), .exec_count(exec_count));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop;
		if (mismatches == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic tick;
		@(negedge ref_clk);
	endtask : tick

	// ------------------------------------------------------------------
	// Shared steps of an instruction handshake
	// ------------------------------------------------------------------
	task automatic accept(input logic [15:0] insn, input int exp_n);
		int n;
		n = 0;
		ir_valid_d = 1'b1;
		ir_insn_d = insn;
		do begin
			tick();
			n++;
		end while (accel_decode_strobe_n !== HAI_STROBE_ON && n < 6);
		ir_valid_d = 1'b0;
		chk(n, exp_n);
		chk(accel_opcode_bus, insn[11:0]);
		chk(accel_unit_sel, insn[11:10]);
		if (n >= 6) begin
			mismatches++;
			report_and_stop();
		end
	endtask : accept

	task automatic expect_issue(input logic exc, input logic dec_n);
		#1;
		chk(core_issue, 1'b1);
		tick();
		chk(accel_issue_strobe_n, HAI_STROBE_ON);
		chk(core_accel_exc_q, exc);
		chk(accel_decode_strobe_n, dec_n);
		tick();
		chk(accel_issue_strobe_n, HAI_STROBE_OFF);
		chk(core_accel_exc_q, 1'b0);
	endtask : expect_issue

	task automatic t_snoop;
		gpr_wr_en = 1'b1;
		gpr_wr_num = 4'hf;
		gpr_wr_data = 32'h1234_5678;
		tick();
		gpr_wr_alt = 1'b1;
		gpr_wr_num = 4'h0;
		gpr_wr_data = 32'hfedc_ba98;
		chk(reg_write_strobe_n, HAI_STROBE_ON);
		chk(snoop_reg_index, 5'h0f);
		chk(accel_data_out, 32'h1234_5678);
		chk(accel_data_oe_n, 1'b0);
		tick();
		gpr_wr_en = 1'b0;
		chk(reg_write_strobe_n, HAI_STROBE_ON);
		chk(snoop_reg_index, 5'h10);
		chk(accel_data_out, 32'hfedc_ba98);
		tick();
		chk(reg_write_strobe_n, HAI_STROBE_OFF);
	endtask : t_snoop

	task automatic t_super;
		psr_supervisor = 1'b0;
		tick();
		chk(accel_supervisor_flag, 1'b0);
		psr_supervisor = 1'b1;
		tick();
		chk(accel_supervisor_flag, 1'b1);
	endtask : t_super

	task automatic t_basic;
		cnt = exec_count;
		ir_valid_d = 1'b1;
		ir_insn_d = 16'h5012;
		tick();
		tick();
		chk(accel_decode_strobe_n, HAI_STROBE_OFF);
		accept(16'h4012, 1);
		expect_issue(1'b0, HAI_STROBE_OFF);
		chk(exec_count, cnt + 1);
	endtask : t_basic

	task automatic t_busy;
		busy_req = 1'b1;
		exc_req = 1'b1;
		accept(16'h4345, 1);
		repeat (3) begin
			#1;
			chk(core_stall, 1'b1);
			chk(core_issue, 1'b0);
			tick();
			chk(accel_decode_strobe_n, HAI_STROBE_ON);
			chk(accel_issue_strobe_n, HAI_STROBE_OFF);
		end
		busy_req = 1'b0;
		exc_req = 1'b0;
		expect_issue(1'b0, HAI_STROBE_OFF);
	endtask : t_busy

	task automatic t_pipe;
		pipe_ready = 1'b0;
		accept(16'h43ff, 1);
		repeat (2) begin
			#1;
			chk(core_issue, 1'b0);
			tick();
			chk(accel_issue_strobe_n, HAI_STROBE_OFF);
			chk(accel_decode_strobe_n, HAI_STROBE_ON);
		end
		pipe_ready = 1'b1;
		expect_issue(1'b0, HAI_STROBE_OFF);
	endtask : t_pipe

	task automatic t_exc;
		cnt = exec_count;
		exc_req = 1'b1;
		accept(16'h4200, 1);
		expect_issue(1'b1, HAI_STROBE_OFF);
		exc_req = 1'b0;
		chk(exec_count, cnt);
	endtask : t_exc

	task automatic t_b2b;
		ir_valid_d = 1'b1;
		ir_insn_d = 16'h4111;
		tick();
		ir_insn_d = 16'h4222;
		chk(accel_decode_strobe_n, HAI_STROBE_ON);
		chk(accel_opcode_bus, 12'h111);
		#1;
		chk(core_issue, 1'b1);
		tick();
		ir_valid_d = 1'b0;
		chk(accel_issue_strobe_n, HAI_STROBE_ON);
		chk(accel_decode_strobe_n, HAI_STROBE_ON);
		chk(accel_opcode_bus, 12'h222);
		expect_issue(1'b0, HAI_STROBE_OFF);
	endtask : t_b2b

	task automatic t_flush;
		ir_valid_d = 1'b1;
		ir_insn_d = 16'h4333;
		flush = 1'b1;
		tick();
		chk(accel_decode_strobe_n, HAI_STROBE_OFF);
		flush = 1'b0;
		cnt = exec_count;
		exc_req = 1'b1;
		accept(16'h4333, 1);
		flush = 1'b1;
		#1;
		chk(core_issue, 1'b0);
		tick();
		flush = 1'b0;
		exc_req = 1'b0;
		chk(accel_decode_strobe_n, HAI_STROBE_OFF);
		chk(accel_issue_strobe_n, HAI_STROBE_OFF);
		chk(core_accel_exc_q, 1'b0);
		accept(16'h4044, 2);
		expect_issue(1'b0, HAI_STROBE_OFF);
		chk(exec_count, cnt + 1);
	endtask : t_flush

	initial begin
		{reset, gpr_wr_en, gpr_wr_alt, ir_valid_d, flush, busy_req, exc_req} = 7'h01 << 6;
		{pipe_ready, psr_supervisor} = 2'h3;
		gpr_wr_num = 4'h0;
		gpr_wr_data = 32'h0000_0000;
		ir_insn_d = 16'h0000;
		mismatches = 0;
		compares = 0;
		repeat (5) tick();
		reset = 1'b0;
		chk({accel_decode_strobe_n, accel_issue_strobe_n, reg_write_strobe_n}, 3'h7);
		chk({accel_data_oe_n, accel_supervisor_flag, core_accel_exc_q}, 3'h6);
		chk(accel_opcode_bus, HAI_OP_RESET);
		t_snoop();
		t_super();
		t_basic();
		t_busy();
		t_pipe();
		t_exc();
		t_b2b();
		t_flush();
		report_and_stop();
	end
endmodule : accel_instr_handshake_tb
